// [design/drc_pkg.sv]
package drc_pkg;
  // ==========================================================
  // command opcodes
  localparam logic [3:0] DRC_OP_RECAL_HI = 4'h1;
  localparam logic [7:0] DRC_OP_DISABLE = 8'hF6;
  localparam logic [7:0] DRC_OP_PREPARE = 8'hF3;
  localparam logic [7:0] DRC_OP_ERASE = 8'hF4;
  // ==========================================================
  // register byte offsets on the avalon side
  localparam logic [3:0] DRC_REG_CMD = 4'h0;
  localparam logic [3:0] DRC_REG_DATA = 4'h4;
  localparam logic [3:0] DRC_REG_STAT = 4'h8;
  // ==========================================================
  // error and status bit positions
  localparam int DRC_ERR_ABT = 2;
  localparam int DRC_ERR_TON = 1;
  localparam int DRC_ST_RDY = 6;
  localparam int DRC_ST_DSC = 4;
  localparam int DRC_ST_DRQ = 3;
  localparam int DRC_ST_ERR = 0;
  localparam int DRC_ST_BSY = 7;
  // ==========================================================
  // password block layout, in 16-bit words; enhanced flag is a control-word bit, password width in bits
  localparam int DRC_CW_IDENT = 0;
  localparam int DRC_CW_ENHANCED = 1;
  localparam int DRC_PW_FIRST = 1;
  localparam int DRC_PW_LAST = 16;
  localparam int DRC_BLOCK_WORDS = 256;
  localparam int DRC_PW_BITS = 256;
  // ==========================================================
  // reset values and timing
  localparam logic [7:0] DRC_STATUS_RST = 8'h50;
  localparam logic [7:0] DRC_ERROR_RST = 8'h00;
  localparam int DRC_SEEK_TIME_US = 1;
  localparam int DRC_CLK_MHZ = 50;
  localparam int DRC_SEEK_CYC = DRC_SEEK_TIME_US * DRC_CLK_MHZ;
  localparam logic [15:0] DRC_ERASE_TIME_ID = 16'h0001;
  localparam int DRC_ID_ERASE_WORD = 89;
endpackage

// [design/drc_if.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// task-file link between host controller and drive
interface drc_if;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic wr_valid;
  logic [15:0] wr_data;
  logic [7:0] status;
  logic [7:0] error;
  modport drive (
    input cmd_valid, cmd_code, wr_valid, wr_data,
    output status, error
  );
  modport host (
    output cmd_valid, cmd_code, wr_valid, wr_data,
    input status, error
  );
endinterface
`default_nettype wire

// [design/drc_host.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// host end: Avalon-MM slave registers steering the task file
module drc_host
  import drc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // task file link
  drc_if.host tf
);
  logic [7:0] cmd_code_q, cmd_code_d;
  logic cmd_valid_q, cmd_valid_d;
  logic [15:0] wr_data_q, wr_data_d;
  logic wr_valid_q, wr_valid_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;

  // ==========================================================
  // decode; one wait cycle per access keeps reads registered
  always_comb begin
    cmd_code_d = cmd_code_q;
    cmd_valid_d = 1'b0;
    wr_data_d = wr_data_q;
    wr_valid_d = 1'b0;
    rdata_d = 32'h0000_0000;
    ack_d = 1'b0;
    if ((avs_read || avs_write) && !ack_q) begin
      ack_d = 1'b1;
      if (avs_read && avs_address == DRC_REG_STAT) begin
        rdata_d = {16'h0000, tf.error, tf.status};
      end else if (avs_read && avs_address == DRC_REG_CMD) begin
        rdata_d = {24'h00_0000, cmd_code_q};
      end
    end else if (avs_write && ack_q) begin
      // write lands only at the edge where waitrequest is low
      if (avs_address == DRC_REG_CMD) begin
        cmd_code_d = avs_writedata[7:0];
        cmd_valid_d = 1'b1;
      end else if (avs_address == DRC_REG_DATA) begin
        // one word per write; a block is 256 of them
        wr_data_d = avs_writedata[15:0];
        wr_valid_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_code_q <= 8'h00;
      cmd_valid_q <= 1'b0;
      wr_data_q <= 16'h0000;
      wr_valid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      cmd_code_q <= cmd_code_d;
      cmd_valid_q <= cmd_valid_d;
      wr_data_q <= wr_data_d;
      wr_valid_q <= wr_valid_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
  assign tf.cmd_code = cmd_code_q;
  assign tf.cmd_valid = cmd_valid_q;
  assign tf.wr_data = wr_data_q;
  assign tf.wr_valid = wr_valid_q;
endmodule
`default_nettype wire

// [design/drc_drive.sv]
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - recalibrate seeks heads to cylinder zero
// - seek failure sets track-zero error bit
// - disable takes one password sector first
// - disable unlocks only on password match
// - disable keeps master password stored
// - host should disable only when unlocked; the drive also accepts disable while locked and unlocks on a match
// - control bit zero picks user or master
// - compare only the password kind selected
// - prepare must precede erase unit
// - prepare has no data phase
// - erase covers lba zero to native max
// - erase password mismatch gives aborted error
// - erase writes zeros then unlocks
// - erase skips verify and defect updates
// - erase without prepare is aborted
// - erase keeps master password stored
// - erase skips compare when lock disabled
// - only normal erase mode supported
// - erase duration reported in identify word
module drc_drive
  import drc_pkg::*;
#(
  parameter int LBA_W = 28,
  parameter logic [27:0] NATIVE_MAX_LBA = 28'h000_00FF
)(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // task file link
  drc_if.drive tf,
  // stored security state
  input wire logic [DRC_PW_BITS-1:0] user_pw,
  input wire logic [DRC_PW_BITS-1:0] master_pw,
  input wire logic lock_preset,
  output logic lock_enabled,
  // mechanics and media
  input wire logic seek_fail,
  output logic [LBA_W-1:0] wipe_lba,
  output logic wipe_wr,
  output logic [15:0] erase_time_word
);
  typedef enum logic [2:0] {
    DRC_IDLE = 3'b000,
    DRC_RECV = 3'b001,
    DRC_CHECK = 3'b011,
    DRC_WIPE = 3'b010,
    DRC_SEEK = 3'b100
  } drc_state_e;

  drc_state_e st_q, st_d;
  logic [7:0] op_q, op_d;
  logic [7:0] status_q, status_d;
  logic [7:0] error_q, error_d;
  logic [7:0] cnt_q, cnt_d;
  logic [15:0] ctl_q, ctl_d;
  logic [DRC_PW_BITS-1:0] pw_q, pw_d;
  logic armed_q, armed_d;
  logic lock_q, lock_d;
  logic lock_init_q, lock_init_d;
  logic [LBA_W-1:0] lba_q, lba_d;
  logic wr_q, wr_d;
  logic match;

  // password compare against the selected kind only
  function automatic logic pw_ok(input logic [15:0] ctl,
                                 input logic [DRC_PW_BITS-1:0] got,
                                 input logic [DRC_PW_BITS-1:0] usr,
                                 input logic [DRC_PW_BITS-1:0] mst);
    pw_ok = ctl[DRC_CW_IDENT] ? (got == mst) : (got == usr);
  endfunction

  assign match = pw_ok(ctl_q, pw_q, user_pw, master_pw);

  // ==========================================================
  // command sequencer
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    status_d = status_q;
    error_d = error_q;
    cnt_d = cnt_q;
    ctl_d = ctl_q;
    pw_d = pw_q;
    armed_d = armed_q;
    lock_d = lock_q;
    lock_init_d = 1'b1;
    lba_d = lba_q;
    wr_d = 1'b0;
    // lock state is captured once after reset release
    if (!lock_init_q) begin
      lock_d = lock_preset;
    end
    case (st_q)
      DRC_IDLE: begin
        if (tf.cmd_valid) begin
          op_d = tf.cmd_code;
          error_d = DRC_ERROR_RST;
          status_d = 8'h00;
          status_d[DRC_ST_BSY] = 1'b1;
          // any command but prepare or erase drops the prepare arming
          armed_d = 1'b0;
          cnt_d = 8'h00;
          if (tf.cmd_code[7:4] == DRC_OP_RECAL_HI) begin
            st_d = DRC_SEEK;
          end else if (tf.cmd_code == DRC_OP_PREPARE) begin
            // no data phase, finish at once
            armed_d = 1'b1;
            status_d = DRC_STATUS_RST;
          end else if (tf.cmd_code == DRC_OP_DISABLE ||
                       tf.cmd_code == DRC_OP_ERASE) begin
            status_d[DRC_ST_DRQ] = 1'b1;
            st_d = DRC_RECV;
            armed_d = armed_q && tf.cmd_code == DRC_OP_ERASE;
          end else begin
            error_d[DRC_ERR_ABT] = 1'b1;
            status_d = DRC_STATUS_RST;
            status_d[DRC_ST_ERR] = 1'b1;
          end
        end
      end
      DRC_SEEK: begin
        // stand-in for seek time of the servo
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == 8'(DRC_SEEK_CYC - 1)) begin
          status_d = DRC_STATUS_RST;
          st_d = DRC_IDLE;
          if (seek_fail) begin
            error_d[DRC_ERR_TON] = 1'b1;
            status_d[DRC_ST_ERR] = 1'b1;
          end
        end
      end
      DRC_RECV: begin
        if (tf.wr_valid) begin
          cnt_d = cnt_q + 8'h01;
          if (cnt_q == 8'(DRC_CW_IDENT)) begin
            ctl_d = tf.wr_data;
          end else if (cnt_q <= 8'(DRC_PW_LAST)) begin
            // words past 16 are reserved and dropped
            pw_d = {tf.wr_data,
                    pw_q[DRC_PW_BITS-1:16]};
          end
          if (cnt_q == 8'(DRC_BLOCK_WORDS - 1)) begin
            status_d[DRC_ST_DRQ] = 1'b0;
            st_d = DRC_CHECK;
          end
        end
      end
      DRC_CHECK: begin
        status_d = DRC_STATUS_RST;
        st_d = DRC_IDLE;
        if (op_q == DRC_OP_DISABLE) begin
          if (match) begin
            // master password input is untouched
            lock_d = 1'b0;
          end else begin
            error_d[DRC_ERR_ABT] = 1'b1;
            status_d[DRC_ST_ERR] = 1'b1;
          end
        end else if (!armed_q || ctl_q[DRC_CW_ENHANCED] ||
                     (lock_q && !match)) begin
          // no prepare, enhanced mode, or bad password
          error_d[DRC_ERR_ABT] = 1'b1;
          status_d[DRC_ST_ERR] = 1'b1;
        end else begin
          // password matched, or unlocked drive erases without compare
          status_d = 8'h00;
          status_d[DRC_ST_BSY] = 1'b1;
          lba_d = '0;
          // first write is lba zero, in step with its address
          wr_d = 1'b1;
          st_d = DRC_WIPE;
        end
        armed_d = 1'b0;
      end
      DRC_WIPE: begin
        // plain zero writes, no read-back, no list update
        if (lba_q == NATIVE_MAX_LBA[LBA_W-1:0]) begin
          // master stays stored; only lock drops
          lock_d = 1'b0;
          status_d = DRC_STATUS_RST;
          st_d = DRC_IDLE;
        end else begin
          wr_d = 1'b1;
          lba_d = LBA_W'(lba_q + 1'b1);
        end
      end
      default: st_d = DRC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= DRC_IDLE;
      op_q <= 8'h00;
      status_q <= DRC_STATUS_RST;
      error_q <= DRC_ERROR_RST;
      cnt_q <= 8'h00;
      ctl_q <= 16'h0000;
      pw_q <= '0;
      armed_q <= 1'b0;
      lock_q <= 1'b0;
      lock_init_q <= 1'b0;
      lba_q <= '0;
      wr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      status_q <= status_d;
      error_q <= error_d;
      cnt_q <= cnt_d;
      ctl_q <= ctl_d;
      pw_q <= pw_d;
      armed_q <= armed_d;
      lock_q <= lock_d;
      lock_init_q <= lock_init_d;
      lba_q <= lba_d;
      wr_q <= wr_d;
    end
  end

  // ==========================================================
  // outputs
  assign tf.status = status_q;
  assign tf.error = error_q;
  assign lock_enabled = lock_q;
  assign wipe_lba = lba_q;
  assign wipe_wr = wr_q;
  assign erase_time_word = DRC_ERASE_TIME_ID;
endmodule
`default_nettype wire

// [test/drc_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// task file rules seen between the two ends
module drc_properties
  import drc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // task file
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic wr_valid,
  input wire logic [15:0] wr_data,
  input wire logic [7:0] status,
  input wire logic [7:0] error
);
  logic idle, go, rcl, unk;
  logic [9:0] words_q, words_d;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // a command counts only when the drive is idle
  assign idle = !status[DRC_ST_BSY] && !status[DRC_ST_DRQ];
  assign go = cmd_valid && idle;
  assign rcl = cmd_code[7:4] == DRC_OP_RECAL_HI;
  assign unk = !rcl && cmd_code != DRC_OP_PREPARE &&
    cmd_code != DRC_OP_ERASE && cmd_code != DRC_OP_DISABLE;
  // data words since the last command
  always_comb begin
    words_d = words_q;
    if (cmd_valid) begin
      words_d = '0;
    end else if (wr_valid) begin
      words_d = words_q + 10'h001;
    end
  end
  always_ff @(posedge clk) begin
    words_q <= srst ? '0 : words_d;
  end
  recal_busy_a: assert property (
    go && rcl |-> ##[1:3] status[DRC_ST_BSY] [*8])
    else $error("recalibrate not busy");
  recal_done_a: assert property (
    go && rcl |-> ##[45:70] idle)
    else $error("recalibrate never ended");
  prep_nodata_a: assert property (
    go && cmd_code == DRC_OP_PREPARE |-> ##1 !status[DRC_ST_DRQ] [*6])
    else $error("prepare asked for data");
  prep_done_a: assert property (
    go && cmd_code == DRC_OP_PREPARE |-> ##[1:3] status == DRC_STATUS_RST)
    else $error("prepare did not finish clean");
  drq_start_a: assert property (
    go && cmd_code == DRC_OP_DISABLE |-> ##[1:3] status[DRC_ST_DRQ])
    else $error("disable asked no data");
  pw_words_a: assert property (
    $fell(status[DRC_ST_DRQ]) |-> words_q == 10'(DRC_BLOCK_WORDS))
    else $error("data phase not one sector");
  abort_bits_a: assert property (
    status[DRC_ST_ERR] && idle |-> error[DRC_ERR_ABT] || error[DRC_ERR_TON])
    else $error("error flag without cause");
  unknown_abort_a: assert property (
    go && unk |-> ##[1:3] status[DRC_ST_ERR] && error[DRC_ERR_ABT])
    else $error("unknown command not aborted");
endmodule
`default_nettype wire

// [test/disk_recal_security_cmds_tb.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// both ends joined, driven over the register bus
module disk_recal_security_cmds_tb
  import drc_pkg::*;
();
  localparam logic [27:0] MAX_LBA = 28'h000_000F;
  localparam logic [255:0] UPW = {8{32'h1357_9BDF}};
  localparam logic [255:0] MPW = {8{32'h2468_ACE0}};
  localparam logic [7:0] ST_E = DRC_STATUS_RST | (8'h01 << DRC_ST_ERR);
  localparam logic [31:0] OK = {24'h0, DRC_STATUS_RST};
  localparam logic [31:0] ABT = {16'h0, 8'h01 << DRC_ERR_ABT, ST_E};
  localparam logic [31:0] TON = {16'h0, 8'h01 << DRC_ERR_TON, ST_E};
  logic clk = 1'b0, srst = 1'b1, seek_fail = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, lock_enabled, wipe_wr;
  logic [27:0] wipe_lba, last_lba, first_lba;
  logic [15:0] erase_time_word;
  int err_total = 0, n_checks = 0, wipes = 0;
  drc_if tf_bus();
  drc_host u_drc_host(.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tf(tf_bus));
  drc_drive #(.NATIVE_MAX_LBA(MAX_LBA)) u_drc_drive(.clk(clk), .srst(srst),
    .tf(tf_bus), .user_pw(UPW), .master_pw(MPW), .lock_preset(1'b1),
    .lock_enabled(lock_enabled), .seek_fail(seek_fail),
    .wipe_lba(wipe_lba), .wipe_wr(wipe_wr),
    .erase_time_word(erase_time_word));
  drc_properties u_drc_properties(.clk(clk), .srst(srst),
    .cmd_valid(tf_bus.cmd_valid), .cmd_code(tf_bus.cmd_code),
    .wr_valid(tf_bus.wr_valid), .wr_data(tf_bus.wr_data),
    .status(tf_bus.status), .error(tf_bus.error));
  // clock and sector write tally
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wipe_wr === 1'b1) begin
      wipes <= wipes + 1;
      last_lba <= wipe_lba;
      if (wipes == 0) begin
        first_lba <= wipe_lba;
      end
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus access; held until waitrequest is sampled low at an edge
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // one idle edge keeps back-to-back calls apart
    @(posedge clk);
  endtask
  // poll status until the drive is idle or asks for data
  task automatic poll();
    do begin
      av(1'b0, DRC_REG_STAT, 32'h0);
    end while (rd[DRC_ST_BSY] !== 1'b0 && rd[DRC_ST_DRQ] !== 1'b1);
  endtask
  // command with a sector of data when the drive asks for it
  task automatic cmd(input logic [7:0] code, input logic [15:0] ctl,
                     input logic [255:0] pw);
    logic [15:0] w;
    av(1'b1, DRC_REG_CMD, {24'h0, code});
    repeat (4) @(posedge clk);
    poll();
    if (rd[DRC_ST_DRQ] === 1'b1) begin
      for (int i = 0; i < DRC_BLOCK_WORDS; i++) begin
        w = i > DRC_PW_LAST ? 16'hC0DE : pw[16*i-16 +: 16];
        av(1'b1, DRC_REG_DATA, {16'h0, i == 0 ? ctl : w});
      end
      repeat (4) @(posedge clk);
      poll();
    end
  endtask
  task automatic rst();
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("lock", lock_enabled, 1);
    chk("erase time", erase_time_word, DRC_ERASE_TIME_ID);
  endtask
  task automatic t_recal();
    for (int f = 0; f < 2; f++) begin
      seek_fail <= f[0];
      cmd(f[0] ? 8'h1F : 8'h10, 16'h0, UPW);
      chk("recal", rd, f[0] ? TON : OK);
    end
    seek_fail <= 1'b0;
    cmd(8'hA5, 16'h0, UPW);
    chk("unknown", rd, ABT);
    $display("test recal done");
  endtask
  task automatic t_refused();
    cmd(DRC_OP_ERASE, 16'h0, UPW);
    chk("no prepare", rd, ABT);
    cmd(DRC_OP_PREPARE, 16'h0, UPW);
    chk("prepare", rd, OK);
    cmd(8'hA5, 16'h0, UPW);
    cmd(DRC_OP_ERASE, 16'h0, UPW);
    chk("stale prepare", rd, ABT);
    cmd(DRC_OP_PREPARE, 16'h0, UPW);
    cmd(DRC_OP_ERASE, 16'h0002, UPW);
    chk("enhanced", rd, ABT);
    cmd(DRC_OP_PREPARE, 16'h0, UPW);
    cmd(DRC_OP_ERASE, 16'h0001, UPW);
    chk("wrong kind", rd, ABT);
    chk("no wipe", 32'(wipes), 0);
    cmd(DRC_OP_DISABLE, 16'h0, MPW);
    chk("disable bad", rd, ABT);
    chk("still locked", lock_enabled, 1);
    cmd(DRC_OP_DISABLE, 16'h0001, MPW);
    chk("disable", rd, OK);
    chk("unlocked", lock_enabled, 0);
    $display("test refusals done");
  endtask
  task automatic t_erase();
    cmd(DRC_OP_PREPARE, 16'h0, UPW);
    cmd(DRC_OP_ERASE, 16'h0, UPW);
    chk("erase", rd, OK);
    chk("sectors", 32'(wipes), 32'(MAX_LBA) + 1);
    chk("first lba", first_lba, 0);
    chk("last lba", last_lba, MAX_LBA);
    chk("unlocked", lock_enabled, 0);
    cmd(DRC_OP_PREPARE, 16'h0, UPW);
    cmd(DRC_OP_ERASE, 16'h0, ~UPW);
    chk("free erase", rd, OK);
    chk("sectors", 32'(wipes), 2 * (32'(MAX_LBA) + 1));
    // disable only once unlocked; master still usable after erase
    cmd(DRC_OP_DISABLE, 16'h0001, MPW);
    chk("master kept", rd, OK);
    $display("test erase done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence; second reset relocks the drive
  initial begin
    rst();
    t_recal();
    t_refused();
    rst();
    t_erase();
    end_of_test();
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
